// file: rtl/fod_decoder.sv
// op and control field decoder with status and host word logic
//
// What this block does
// RL1: internal phase enable active every second master clock.
// RL2: optional serial clock enable every eighth master clock.
// RL3: a masked interrupt request is latched in the memo flag.
// RL4: maskable and nonmaskable interrupts; 20-bit status register.
// RL5: serial in uses internal or external clock; ext out bit is stored only.
// RL6: serial in word length 8, 16, 24 or 32; out length field is stored only.
// RL7: master mode: 8K space, low 4K code or data, high data only.
// RL8: slave mode: no external fetch, full 8K for data.
// RL9: slave mode host word built from successive bytes.
// RL10: host exchange over 16-bit bus, 16- or 32-bit words.
// RL11: slave mode two testable inputs, two driven outputs.
// RL12: every instruction is one 32-bit word of three formats.
// RL13: operation taken from bits 31 to 27, 26 codes.
// RL14: function codes mapped in order from 00000 to 11001.
// RL15: 12-bit control field holding grouped sub-fields.
// RL16: two-bit field selects the second operand source.
// RL17: each flag kept, forced 0, forced 1 or from result.
// RL18: select, clear or swap the two flag words.
// RL19: interrupt sub-field in bits 19 to 17 decoded per code.
// RL20: after reset interrupts disabled and memo flag clear.
// RL21: immediate sub-field gives low nine data ROM bits.
// RL22: per-pointer sub-field sets modulo counter length.
// RL23: operand loads from main bus, either RAM, or multiplier.
// RL24: prohibited interrupt code acts as no operation.
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "fod_params.svh"
module fod_decoder (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // wait request
  input wire logic insn_valid, // instruction issue pulse
  input wire logic [31:0] insn_word, // instruction word
  input wire logic [4:0] alu_result_flags, // result flags e,c,z,s,m
  input wire logic irq_mask_in, // maskable request pin
  input wire logic irq_nmi_in, // nonmaskable request pin
  input wire logic [1:0] gp_in, // general inputs
  output logic [1:0] gp_out, // general outputs
  input wire logic ser_ext_clk_in, // external serial clock pin
  output logic phase_en, // internal phase enable
  output logic ser_clk_en, // serial shift enable
  output logic irq_take, // maskable interrupt taken
  output logic nmi_take, // nonmaskable interrupt taken
  output fod_pkg::fod_op_t op_code, // decoded operation
  output logic op_legal, // operation code valid
  output fod_pkg::fod_psrc_t p_source, // second operand source
  output logic [11:0] control_subfields, // control field
  output logic [8:0] rom_addr_immediate, // low rom address
  output logic [2:0] ptr0_modulo_length, // pointer 0 length
  output logic [2:0] ptr1_modulo_length, // pointer 1 length
  output logic [4:0] processor_flag_word, // active flag word
  input wire logic [12:0] ext_addr, // external access address
  input wire logic ext_fetch, // external fetch request
  output logic ext_ok // external access allowed
);
  import fod_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl; // 0 slave,1 ser ext in,2 ext out,3 div8,4 host32
  // [6:5] serial in length, [8:7] out length, [10:9] byte count
  logic irq_enable;
  logic memo_flag;
  logic flag_sel;
  logic [4:0] flag_word0;
  logic [4:0] flag_word1;
  logic [31:0] host_word_register;
  logic [1:0] host_byte_idx;
  logic host_hi_pending;
  logic [1:0] gp_in_s1, gp_in_s2;
  logic irq_s1, irq_s2, irq_s3;
  logic nmi_s1, nmi_s2, nmi_s3;
  logic se_s1, se_s2, se_s3;
  logic [2:0] div_cnt;
  logic [4:0] ser_len_cnt;

  wire logic slave_mode = ctrl[0];
  wire logic bus_req = avs_read | avs_write;

  // ----------------------------------------
  // clock enables
  // ----------------------------------------
  // phase and serial dividers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end
  assign phase_en = div_cnt[0]; // see RL1
  // external serial clock edge, internal divide-by-eight, else phase enable
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      se_s1 <= 1'b0;
      se_s2 <= 1'b0;
      se_s3 <= 1'b0;
    end else begin
      se_s1 <= ser_ext_clk_in;
      se_s2 <= se_s1;
      se_s3 <= se_s2;
    end
  end
  always_comb begin
    if (ctrl[1]) begin
      ser_clk_en = se_s2 & ~se_s3; // see RL5
    end else if (ctrl[3]) begin
      ser_clk_en = (div_cnt == 3'h7); // see RL2
    end else begin
      ser_clk_en = phase_en;
    end
  end
  // bits shifted in current serial word, wraps at length
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ser_len_cnt <= 5'h00;
    end else if (ser_clk_en) begin
      if (ser_len_cnt >= {ctrl[6:5], 3'h7}) begin
        ser_len_cnt <= 5'h00; // see RL6
      end else begin
        ser_len_cnt <= ser_len_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire logic [4:0] op_bits = insn_word[`FOD_OP_MSB:`FOD_OP_LSB];
  wire logic [2:0] irq_code = insn_word[`FOD_IRQ_MSB:`FOD_IRQ_LSB];
  wire logic [2:0] fis_code = insn_word[`FOD_FIS_MSB:`FOD_FIS_LSB];
  // whole word decoded in one step
  always_comb begin
    op_legal = (op_bits <= 5'h19); // see RL12
    op_code = op_legal ? fod_op_t'(op_bits) : FOD_NOP; // see RL13
    p_source = fod_psrc_t'(insn_word[`FOD_P_MSB:`FOD_P_LSB]); // see RL16
    control_subfields = insn_word[`FOD_CNT_MSB:`FOD_CNT_LSB]; // see RL15
    rom_addr_immediate = insn_word[`FOD_RPS_MSB:`FOD_RPS_LSB]; // see RL21
    ptr0_modulo_length = insn_word[`FOD_B0_MSB:`FOD_B0_LSB]; // see RL22
    ptr1_modulo_length = insn_word[`FOD_B1_MSB:`FOD_B1_LSB]; // see RL22
  end
  // see RL23: p_source codes bus, ram0, ram1, multiplier

  // flag action per operation, order e,c,z,s,m
  function automatic fod_fact_t fod_act(input fod_op_t op, input int i);
    fod_fact_t a [5];
    a = '{FOD_KEEP, FOD_RES, FOD_RES, FOD_RES, FOD_RES};
    case (op)
      FOD_NOP: a = '{FOD_KEEP, FOD_KEEP, FOD_KEEP, FOD_KEEP, FOD_KEEP};
      FOD_NOT: a = '{FOD_KEEP, FOD_RES, FOD_RES, FOD_ZERO, FOD_RES};
      FOD_SHRC: a = '{FOD_KEEP, FOD_RES, FOD_RES, FOD_RES, FOD_ZERO};
      FOD_ROL, FOD_ROR:
        a = '{FOD_KEEP, FOD_ZERO, FOD_KEEP, FOD_RES, FOD_ZERO};
      FOD_CLR: a = '{FOD_ZERO, FOD_ZERO, FOD_ONE, FOD_ZERO, FOD_ZERO};
      FOD_NORM: a = '{FOD_RES, FOD_ZERO, FOD_RES, FOD_RES, FOD_ZERO};
      FOD_NEG, FOD_CVT, FOD_SHLM, FOD_SHRM, FOD_SHRAM, FOD_CMP, FOD_AND,
      FOD_OR:
        a = '{FOD_KEEP, FOD_ZERO, FOD_RES, FOD_RES, FOD_ZERO};
      FOD_SUBC, FOD_XOR, FOD_ADDF, FOD_SUBF:
        a = '{FOD_RES, FOD_RES, FOD_RES, FOD_RES, FOD_RES};
      default: a = '{FOD_KEEP, FOD_RES, FOD_RES, FOD_RES, FOD_RES};
    endcase
    return a[i];
  endfunction : fod_act

  logic [4:0] next_flags;
  // new flag word from per-bit actions
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      case (fod_act(op_code, i))
        FOD_ZERO: next_flags[4-i] = 1'b0; // see RL17
        FOD_ONE: next_flags[4-i] = 1'b1;
        FOD_RES: next_flags[4-i] = alu_result_flags[4-i];
        default: next_flags[4-i] = processor_flag_word[4-i];
      endcase
    end
  end
  assign processor_flag_word = flag_sel ? flag_word1 : flag_word0;

  // ----------------------------------------
  // flag words
  // ----------------------------------------
  wire logic sel_after = fis_code == 3'h1 ? 1'b0 :
    fis_code == 3'h2 ? 1'b1 : flag_sel ^ insn_word[`FOD_FC_BIT];
  // flag word select, clear, swap and update
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flag_sel <= 1'b0;
      flag_word0 <= 5'h00;
      flag_word1 <= 5'h00;
    end else if (insn_valid) begin
      flag_sel <= sel_after; // see RL18
      if (fis_code == 3'h4 || fis_code == 3'h6) begin
        flag_word0 <= 5'h04; // zero set, rest clear
      end else if (!flag_sel) begin
        flag_word0 <= next_flags;
      end
      if (fis_code == 3'h5 || fis_code == 3'h6) begin
        flag_word1 <= 5'h04;
      end else if (flag_sel) begin
        flag_word1 <= next_flags;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // request synchronisers and edge detect
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_s3 <= 1'b0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
    end else begin
      irq_s1 <= irq_mask_in;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      nmi_s1 <= irq_nmi_in;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end
  wire logic irq_evt = irq_s2 & ~irq_s3;
  assign nmi_take = nmi_s2 & ~nmi_s3; // see RL4
  assign irq_take = irq_enable & (irq_evt | memo_flag);
  wire logic cmd_ok = insn_valid && irq_code != 3'h7; // see RL24
  // enable and memo flag; a new request beats a clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_enable <= 1'b0; // see RL20
      memo_flag <= 1'b0;
    end else begin
      if (cmd_ok && irq_code == 3'h3) begin
        irq_enable <= 1'b0; // see RL19
      end else if (cmd_ok && irq_code[2]) begin
        irq_enable <= 1'b1;
      end
      if (irq_evt && !irq_enable) begin
        memo_flag <= 1'b1; // see RL3
      end else if (irq_take) begin
        memo_flag <= 1'b0;
      end else if (cmd_ok && (irq_code == 3'h1 || irq_code == 3'h5)) begin
        memo_flag <= 1'b0;
      end else if (cmd_ok && (irq_code == 3'h2 || irq_code == 3'h6)) begin
        memo_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // slave pins and memory map
  // ----------------------------------------
  // general inputs synchronised for testing
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gp_in_s1 <= 2'h0;
      gp_in_s2 <= 2'h0;
    end else begin
      gp_in_s1 <= gp_in;
      gp_in_s2 <= gp_in_s1;
    end
  end
  // output pins held until changed, slave only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gp_out <= 2'h0;
    end else if (insn_valid && slave_mode && op_legal) begin
      gp_out <= {insn_word[21], insn_word[20]}; // see RL11
    end
  end
  // external access legality
  always_comb begin
    if (slave_mode) begin
      ext_ok = !ext_fetch && ext_addr <= `FOD_SLAVE_ADDR_TOP; // see RL8
    end else begin
      ext_ok = !ext_fetch || ext_addr <= `FOD_MASTER_INSN_TOP; // see RL7
    end
  end

  // ----------------------------------------
  // bus slave and host word
  // ----------------------------------------
  assign avs_waitrequest = 1'b0; // zero-wait answer
  // control register writes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl <= 32'h0000_0000;
    end else if (avs_write && avs_address == `FOD_REG_CTRL) begin
      ctrl <= {21'h0, avs_writedata[10:0]};
    end
  end
  // host word: bytes when write data bit 16 is set, else 16-bit halves from host port
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      host_word_register <= 32'h0000_0000;
      host_byte_idx <= 2'h0;
      host_hi_pending <= 1'b0;
    end else if (avs_write && avs_address == `FOD_REG_HOST) begin
      if (avs_writedata[16]) begin
        host_word_register[8*host_byte_idx +: 8] <= avs_writedata[7:0];
        host_byte_idx <= (host_byte_idx == ctrl[10:9]) ? 2'h0 :
          host_byte_idx + 2'h1; // see RL9
      end else if (ctrl[4] && host_hi_pending) begin
        host_word_register[31:16] <= avs_writedata[15:0]; // see RL10
        host_hi_pending <= 1'b0;
      end else begin
        host_word_register[15:0] <= avs_writedata[15:0];
        host_hi_pending <= ctrl[4];
      end
    end
  end
  // read mux
  always_comb begin
    case (avs_address)
      `FOD_REG_CTRL: avs_readdata = ctrl;
      `FOD_REG_STATUS: avs_readdata = {12'h0, memo_flag, irq_enable,
        flag_sel, gp_in_s2, gp_out, host_hi_pending, host_byte_idx,
        ser_len_cnt, processor_flag_word}; // see RL4
      `FOD_REG_INSN: avs_readdata = {22'h0, op_legal, op_code,
        fis_code, 1'b0};
      `FOD_REG_HOST: avs_readdata = host_word_register;
      default: avs_readdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence dis_cmd;
    insn_valid && insn_word[19:17] == 3'h3;
  endsequence
  phase_toggle_a: assert property (phase_en |=> !phase_en) // see RL1
    else $error("phase enable not halved");
  ser_div_a: assert property (!ctrl[1] && ctrl[3] && ser_clk_en
    |=> !ser_clk_en [*7]) // see RL2
    else $error("serial enable not divide by eight");
  memo_set_a: assert property (irq_evt && !irq_enable
    |=> memo_flag) // see RL3
    else $error("masked request not latched");
  irq_off_a: assert property (dis_cmd |=> !irq_enable) // see RL19
    else $error("disable ignored");
  bad_code_a: assert property (insn_valid && irq_code == 3'h7 && !irq_evt
    && !irq_take |=> $stable(irq_enable) && $stable(memo_flag)) // see RL24
    else $error("prohibited code changed state");
  clr_word_a: assert property (insn_valid && fis_code == 3'h6
    |=> flag_word0 == 5'h04 && flag_word1 == 5'h04) // see RL18
    else $error("flag words not cleared");
  clr_op_a: assert property (insn_valid && op_code == FOD_CLR
    && fis_code == 3'h0 && !insn_word[15] |=> processor_flag_word
    == 5'h04) // see RL17
    else $error("clear op flags wrong");
  slave_fetch_a: assert property (slave_mode && ext_fetch
    |-> !ext_ok) // see RL8
    else $error("slave fetch allowed");
  master_hi_a: assert property (!slave_mode && ext_fetch
    && ext_addr[12] |-> !ext_ok) // see RL7
    else $error("fetch from data half");
endmodule : fod_decoder

// file: rtl/fod_params.svh
// constants for the op and control field decoder
`ifndef FOD_PARAMS_SVH
`define FOD_PARAMS_SVH
`define FOD_MCLK_DIV 2
`define FOD_SCLK_DIV 8
`define FOD_SER_EXT_MAX_KHZ 4000
`define FOD_CLK_KHZ 100000
`define FOD_SER_EXT_MIN_CYC ((`FOD_CLK_KHZ + 2*`FOD_SER_EXT_MAX_KHZ - 1) \
  / (2*`FOD_SER_EXT_MAX_KHZ))
`define FOD_OP_MSB 31
`define FOD_OP_LSB 27
`define FOD_IRQ_MSB 19
`define FOD_IRQ_LSB 17
`define FOD_FIS_MSB 21
`define FOD_FIS_LSB 19
`define FOD_FC_BIT 15
`define FOD_RPS_MSB 23
`define FOD_RPS_LSB 15
`define FOD_B0_MSB 21
`define FOD_B0_LSB 19
`define FOD_B1_MSB 18
`define FOD_B1_LSB 16
`define FOD_P_MSB 26
`define FOD_P_LSB 25
`define FOD_CNT_MSB 26
`define FOD_CNT_LSB 15
`define FOD_SLAVE_ADDR_TOP 13'h1fff
`define FOD_MASTER_INSN_TOP 13'h0fff
`define FOD_REG_CTRL 4'h0
`define FOD_REG_STATUS 4'h4
`define FOD_REG_INSN 4'h8
`define FOD_REG_HOST 4'hc
`define FOD_STATUS_BITS 20
`endif

// file: rtl/fod_pkg.sv
// types for the op and control field decoder
package fod_pkg;
  typedef enum logic [4:0] {
    FOD_NOP, FOD_INC, FOD_DEC, FOD_ABS, FOD_NOT, FOD_NEG, FOD_SHLC,
    FOD_SHRC, FOD_ROL, FOD_ROR, FOD_SHLM, FOD_SHRM, FOD_SHRAM, FOD_CLR,
    FOD_NORM, FOD_CVT, FOD_ADD, FOD_SUB, FOD_ADDC, FOD_SUBC, FOD_CMP,
    FOD_AND, FOD_OR, FOD_XOR, FOD_ADDF, FOD_SUBF
  } fod_op_t;
  // flag action: keep, force 0, force 1, from result
  typedef enum logic [1:0] {
    FOD_KEEP, FOD_ZERO, FOD_ONE, FOD_RES
  } fod_fact_t;
  typedef enum logic [1:0] {
    FOD_P_BUS, FOD_P_RAM0, FOD_P_RAM1, FOD_P_MUL
  } fod_psrc_t;
endpackage : fod_pkg

// file: verif/fod_far_model.sv
// far side model: interrupt sources and external serial clock
`timescale 1ns/1ps
module fod_far_model (
  input wire logic clk_sys, // system clock
  input wire logic irq_req, // ask for a maskable event
  input wire logic nmi_req, // ask for a nonmaskable event
  input wire logic ser_run, // let the serial clock run
  output logic irq_mask_in, // maskable request pin
  output logic irq_nmi_in, // nonmaskable request pin
  output logic ser_ext_clk_in // external serial clock pin
);
  int hold_m = 0;
  int hold_n = 0;
  // hold each request pin for four clocks so the sync sees it
  always @(posedge clk_sys) begin
    hold_m <= irq_req ? 4 : (hold_m > 0 ? hold_m - 1 : 0);
    hold_n <= nmi_req ? 4 : (hold_n > 0 ? hold_n - 1 : 0);
  end
  assign irq_mask_in = (hold_m > 0);
  assign irq_nmi_in = (hold_n > 0);
  // 4 mhz at most, parked low while not running
  initial begin
    ser_ext_clk_in = 1'b0;
    // offset so pin edges never meet a clock edge
    #2;
    forever begin
      #125;
      ser_ext_clk_in = ser_run ? !ser_ext_clk_in : 1'b0;
    end
  end
endmodule : fod_far_model

// file: verif/test_fod_decoder.sv
// self-checking bench for the op and control field decoder
`timescale 1ns/1ps
module test_fod_decoder;
  import fod_pkg::*;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, insn_valid;
  logic irq_mask_in, irq_nmi_in, ser_ext_clk_in, phase_en, ser_clk_en;
  logic irq_take, nmi_take, op_legal, ext_fetch, ext_ok;
  logic irq_req, nmi_req, ser_run, e, m, s;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, insn_word, w;
  logic [4:0] alu_result_flags, processor_flag_word, f, p[2];
  logic [1:0] gp_in, gp_out;
  logic [2:0] c, ptr0_modulo_length, ptr1_modulo_length;
  fod_op_t op_code;
  fod_psrc_t p_source;
  logic [11:0] control_subfields;
  logic [8:0] rom_addr_immediate;
  logic [12:0] ext_addr;
  logic [31:0] exp_q[$], msk_q[$];
  fod_op_t opl[5] = '{FOD_NOP, FOD_CLR, FOD_NEG, FOD_ROL, FOD_ADDF};
  logic [9:0] act[5] = '{10'h0, 10'h165, 10'h07d, 10'h04d, 10'h3ff};
  int error_cnt = 0;
  int num_checks = 0;
  int nmi_cnt = 0;
  int irq_cnt = 0;
  int k, n0, ph, sc;

  fod_decoder DUT (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .insn_valid(insn_valid),
    .insn_word(insn_word), .alu_result_flags(alu_result_flags),
    .irq_mask_in(irq_mask_in), .irq_nmi_in(irq_nmi_in), .gp_in(gp_in),
    .gp_out(gp_out), .ser_ext_clk_in(ser_ext_clk_in), .phase_en(phase_en),
    .ser_clk_en(ser_clk_en), .irq_take(irq_take), .nmi_take(nmi_take),
    .op_code(op_code), .op_legal(op_legal), .p_source(p_source),
    .control_subfields(control_subfields),
    .rom_addr_immediate(rom_addr_immediate),
    .ptr0_modulo_length(ptr0_modulo_length),
    .ptr1_modulo_length(ptr1_modulo_length),
    .processor_flag_word(processor_flag_word), .ext_addr(ext_addr),
    .ext_fetch(ext_fetch), .ext_ok(ext_ok)
  );

  fod_far_model far (
    .clk_sys(clk_sys), .irq_req(irq_req), .nmi_req(nmi_req),
    .ser_run(ser_run), .irq_mask_in(irq_mask_in),
    .irq_nmi_in(irq_nmi_in), .ser_ext_clk_in(ser_ext_clk_in)
  );

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // note the expected read value, then read
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, msk);
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // issue one instruction and let its state update land
  task automatic issue(input logic [31:0] wd, input logic [4:0] fl);
    @(posedge clk_sys);
    insn_valid <= 1'b1;
    insn_word <= wd;
    alu_result_flags <= fl;
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : issue

  task automatic ext(input logic [12:0] a, input logic fe, ok);
    @(posedge clk_sys);
    ext_addr <= a;
    ext_fetch <= fe;
    #1;
    check(ext_ok, ok);
  endtask : ext

  task automatic count_en(input int cyc, output int ph, output int sc);
    ph = 0;
    sc = 0;
    repeat (cyc) begin
      @(posedge clk_sys);
      #1;
      ph += (phase_en === 1'b1);
      sc += (ser_clk_en === 1'b1);
    end
  endtask : count_en

  // flag update per action code: keep, zero, one, result
  function automatic logic [4:0] apply(logic [4:0] old, res,
                                       logic [9:0] ac);
    logic [4:0] r;
    for (int b = 0; b < 5; b++) begin
      case (ac[2*b +: 2])
        2'd0: r[b] = old[b];
        2'd1: r[b] = 1'b0;
        2'd2: r[b] = 1'b1;
        default: r[b] = res[b];
      endcase
    end
    return r;
  endfunction : apply

  // read monitor takes the oldest note per accepted read
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    if (nmi_take === 1'b1) nmi_cnt++;
    if (irq_take === 1'b1) irq_cnt++;
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #500000;
    error_cnt++;
    final_report();
  end

  initial begin
    void'($urandom(32'h2b95));
    {nrst, avs_read, avs_write, insn_valid, ext_fetch} = '0;
    {irq_req, nmi_req, ser_run, s} = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    insn_word = 32'h0;
    alu_result_flags = 5'h0;
    gp_in = 2'b00;
    ext_addr = 13'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(4'h4, 32'h0, 32'h000c001f);
    rd(4'h2, 32'h0, 32'hffffffff);
    // interrupt sub-field, every code then random ones
    e = 0;
    m = 0;
    for (int i = 0; i < 16; i++) begin
      c = (i < 8) ? 3'(i) : 3'($urandom);
      n0 = irq_cnt;
      issue(32'(c) << 17, 5'h0);
      case (c)
        3'd1: m = 0;
        3'd2: m = 1;
        3'd3: e = 0;
        3'd4: e = 1;
        3'd5: {e, m} = 2'b10;
        3'd6: {e, m} = 2'b11;
        default: ;
      endcase
      check(irq_cnt - n0, e & m);
      m = m & ~e;
      rd(4'h4, {m, e, 18'h0}, 32'h000c0000);
    end
    // masked request is memorised, then taken on enable
    issue(32'h3 << 17, 5'h0);
    issue(32'h1 << 17, 5'h0);
    @(posedge clk_sys);
    irq_req <= 1'b1;
    @(posedge clk_sys);
    irq_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(4'h4, 32'h00080000, 32'h000c0000);
    check(irq_take, 1'b0);
    n0 = irq_cnt;
    issue(32'h4 << 17, 5'h0);
    check(irq_cnt - n0, 1);
    rd(4'h4, 32'h00040000, 32'h000c0000);
    n0 = nmi_cnt;
    @(posedge clk_sys);
    nmi_req <= 1'b1;
    @(posedge clk_sys);
    nmi_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check(nmi_cnt - n0, 1);
    // field decode over every op code with random remaining bits
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      insn_word <= {5'(i), 27'($urandom)};
      #1;
      w = insn_word;
      check(op_code, w[31:27] < 26 ? w[31:27] : 5'h0);
      check(op_legal, w[31:27] < 26);
      check(p_source, w[26:25]);
      check(control_subfields, w[26:15]);
      check(rom_addr_immediate, w[23:15]);
      check({ptr0_modulo_length, ptr1_modulo_length}, w[21:16]);
    end
    // flag words: select, update per op, swap, clear
    issue(32'h00300000, 5'h0);
    p[0] = 5'h04;
    p[1] = 5'h04;
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 5;
      s = 1'($urandom);
      issue(s ? 32'h00100000 : 32'h00080000, 5'h0);
      f = 5'($urandom);
      issue({opl[k], 27'h0}, f);
      p[s] = apply(p[s], f, act[k]);
      check(processor_flag_word, p[s]);
      if (i % 6 == 5) begin
        issue(32'h00008000, 5'h0);
        s = !s;
        check(processor_flag_word, p[s]);
      end
    end
    issue(32'h00300000, 5'h0);
    check(processor_flag_word, 5'h04);
    // clock division, then external serial clock held still
    bus(1'b1, 4'h0, 32'h8);
    count_en(16, ph, sc);
    check(ph, 8);
    check(sc, 2);
    bus(1'b1, 4'h0, 32'h2);
    count_en(16, ph, sc);
    check(sc, 0);
    // external serial clock running: one enable per pin period
    ser_run <= 1'b1;
    repeat (40) @(posedge clk_sys);
    count_en(100, ph, sc);
    check(sc, 4);
    ser_run <= 1'b0;
    // external space in master then slave mode
    ext(13'h0fff, 1'b1, 1'b1);
    ext(13'h1000, 1'b1, 1'b0);
    ext(13'h1fff, 1'b0, 1'b1);
    bus(1'b1, 4'h0, 32'h1);
    ext(13'h0000, 1'b1, 1'b0);
    ext(13'h1fff, 1'b0, 1'b1);
    @(posedge clk_sys);
    gp_in <= 2'b10;
    issue(32'h08300000, 5'h0);
    check(gp_out, 2'b11);
    rd(4'h4, 32'h00016000, 32'h0001e000);
    // host word: four bytes, then two 16-bit halves
    bus(1'b1, 4'h0, 32'h601);
    w = $urandom;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'hc, {15'h0, 1'b1, 8'h0, w[8*i +: 8]});
    end
    rd(4'hc, w, 32'hffffffff);
    bus(1'b1, 4'h0, 32'h11);
    w = $urandom;
    bus(1'b1, 4'hc, {16'h0, w[15:0]});
    bus(1'b1, 4'hc, {16'h0, w[31:16]});
    rd(4'hc, w, 32'hffffffff);
    repeat (2) @(posedge clk_sys);
    final_report();
  end
endmodule : test_fod_decoder
